/* logic/smsf_consts.svh */
// constants for the safety module state and fault signaller
`ifndef SMSF_CONSTS_SVH
`define SMSF_CONSTS_SVH
`define SMSF_CLK_MHZ        250
`define SMSF_SAFE_W         3
`define SMSF_SIG_W          4
`define SMSF_IN_W           8
`define SMSF_CODE_W         4
`define SMSF_CNT_W          32
`define SMSF_POWER_ON_MS    1000
`define SMSF_FLASH_ON_MS    250
`define SMSF_FLASH_GAP_MS   250
`define SMSF_PAUSE_MS       1500
`define SMSF_MS_CYCLES(ms)  ((ms) * 1000 * `SMSF_CLK_MHZ)
`define SMSF_RED_ONE        4'h1
`define SMSF_BLUE_OVERCUR   4'h1
`define SMSF_BLUE_SHORT     4'h2
`define SMSF_BLUE_TEMP      4'h3
`define SMSF_ZERO_CODE      4'h0
`define SMSF_ZERO_CNT       32'h0
`endif

/* logic/smsf_pkg.sv */
// types for the safety module state and fault signaller
`include "smsf_consts.svh"
package smsf_pkg;
	typedef enum logic [1:0]
	{
		SMSF_POWER_ON = 2'h0,
		SMSF_RUN      = 2'h1,
		SMSF_ERROR    = 2'h3
	} smsf_state_t;

	typedef enum logic [1:0]
	{
		SMSF_PH_ON    = 2'h0,
		SMSF_PH_GAP   = 2'h1,
		SMSF_PH_PAUSE = 2'h3
	} smsf_phase_t;

	typedef enum logic [2:0]
	{
		SMSF_ERR_NONE     = 3'h0,
		SMSF_ERR_INTERNAL = 3'h1,
		SMSF_ERR_OVERCUR  = 3'h2,
		SMSF_ERR_SHORT    = 3'h3,
		SMSF_ERR_TEMP     = 3'h4,
		SMSF_ERR_APP      = 3'h5
	} smsf_err_t;

	typedef struct packed
	{
		smsf_state_t                st;
		smsf_err_t                  err;
		smsf_phase_t                ph;
		logic [`SMSF_CNT_W-1:0]     cnt;
		logic [`SMSF_CODE_W-1:0]    red_n;
		logic [`SMSF_CODE_W-1:0]    blue_n;
		logic [`SMSF_CODE_W-1:0]    red_left;
		logic [`SMSF_CODE_W-1:0]    blue_left;
		logic                       flash_red;
		logic [`SMSF_IN_W-1:0]      sync1;
		logic [`SMSF_IN_W-1:0]      sync2;
		logic [`SMSF_IN_W-1:0]      inputs;
		logic [`SMSF_SAFE_W-1:0]    safe;
		logic [`SMSF_SIG_W-1:0]     sig;
		logic                       lamp_red;
		logic                       lamp_blue;
	} smsf_reg_t;
endpackage

/* logic/smsf_top.sv */
// supervisory state machine, safety output gating and lamp flash codes
//
// Function
// R1: at power-up enter power-on, self-test, both processor lamps red about one second
// R2: self-test passes: lamps off, enter run, start application evaluation
// R3: power-on tests fail: enter error, both processor lamps steady red
// R4: run state without fault keeps both processor lamps dark
// R5: application may force error and report a code as lamp flashes
// R6: internal hardware checks run during run state; malfunction forces error
// R7: entering error opens every safety output
// R8: in error the application is not evaluated and system inputs are ignored
// R9: in error signalling outputs hold their last application values
// R10: error is latched; only a power cycle leaves it
// R11: supply and input status lamps are driven directly from power-up
// R12: steady red on both processor lamps marks a non-restorable internal fault
// R13: output overcurrent shows one red flash then one blue flash
// R14: safety output short shows one red flash then two blue flashes
// R15: temperature out of limits shows one red flash then three blue flashes
// R16: application error code N shows N blue flashes, no red
// R17: flash codes repeat in error, separated by a fixed pause
// R18: safety outputs stay open throughout the power-on state
`timescale 1ns/1ps
`include "smsf_consts.svh"
module smsf_top
	import smsf_pkg::*;
#(
	parameter logic [`SMSF_CNT_W-1:0] POWER_ON_CYCLES = `SMSF_CNT_W'(`SMSF_MS_CYCLES(`SMSF_POWER_ON_MS)),
	parameter logic [`SMSF_CNT_W-1:0] FLASH_ON_CYCLES = `SMSF_CNT_W'(`SMSF_MS_CYCLES(`SMSF_FLASH_ON_MS)),
	parameter logic [`SMSF_CNT_W-1:0] FLASH_GAP_CYCLES = `SMSF_CNT_W'(`SMSF_MS_CYCLES(`SMSF_FLASH_GAP_MS)),
	parameter logic [`SMSF_CNT_W-1:0] PAUSE_CYCLES = `SMSF_CNT_W'(`SMSF_MS_CYCLES(`SMSF_PAUSE_MS))
)
(
	// clock and reset (reset only from supply return)
	input  wire logic                       clk_sys,
	input  wire logic                       arst_n,
	// field input pins: guards, emergency stop, start
	input  wire logic [`SMSF_IN_W-1:0]      in_pins,
	// internal diagnosis
	input  wire logic                       self_test_fail,
	input  wire logic                       hw_fault,
	input  wire logic                       overcurrent_fault,
	input  wire logic                       os_short_fault,
	input  wire logic                       over_temp_fault,
	// application logic
	output logic                            app_run,
	output logic [`SMSF_IN_W-1:0]           sys_inputs,
	input  wire logic [`SMSF_SAFE_W-1:0]    app_safe,
	input  wire logic [`SMSF_SIG_W-1:0]     app_signal,
	input  wire logic                       app_error_req,
	input  wire logic [`SMSF_CODE_W-1:0]    app_error_code,
	// field outputs
	output logic [`SMSF_SAFE_W-1:0]         safe_switch_outputs,
	output logic [`SMSF_SIG_W-1:0]          signal_outputs,
	// lamps
	output logic                            processor_lamp_a_red,
	output logic                            processor_lamp_a_blue,
	output logic                            processor_lamp_b_red,
	output logic                            processor_lamp_b_blue,
	output logic                            supply_lamp,
	output logic [`SMSF_IN_W-1:0]           input_lamps
);

	smsf_reg_t  r;
	smsf_reg_t  next_r;
	// fault kind taken in this run cycle, none while healthy
	smsf_err_t  run_err;

	// priority among faults seen in the same run cycle
	always_comb
	begin
		if (hw_fault)
			run_err = SMSF_ERR_INTERNAL;
		else if (overcurrent_fault)
			run_err = SMSF_ERR_OVERCUR;
		else if (os_short_fault)
			run_err = SMSF_ERR_SHORT;
		else if (over_temp_fault)
			run_err = SMSF_ERR_TEMP;
		else if (app_error_req)
			run_err = SMSF_ERR_APP;
		else
			run_err = SMSF_ERR_NONE;
	end

	always_comb
	begin
		next_r = r;
		// two flops: the field contacts move with no regard to this clock
		next_r.sync1 = in_pins;
		next_r.sync2 = r.sync1;

		case (r.st)
			SMSF_POWER_ON:
			begin
				next_r.safe = '0; // R18
				next_r.sig = '0;
				// a self-test failure or hardware fault here means the module itself is suspect; other faults are not checked here
				if (self_test_fail || hw_fault)
				begin
					next_r.st = SMSF_ERROR; // R3
					next_r.err = SMSF_ERR_INTERNAL; // R12
				end
				else if (r.cnt >= POWER_ON_CYCLES - `SMSF_CNT_W'(1))
				begin
					next_r.st = SMSF_RUN; // R2
					next_r.cnt = `SMSF_ZERO_CNT;
				end
				else
				begin
					// the same counter later times the flashes; the two uses never overlap
					next_r.cnt = r.cnt + `SMSF_CNT_W'(1); // R1
				end
			end

			SMSF_RUN:
			begin
				if (run_err != SMSF_ERR_NONE)
				begin
					// R6
					next_r.st = SMSF_ERROR; // R5
					next_r.err = run_err;
					next_r.safe = '0; // R7
					next_r.ph = SMSF_PH_GAP;
					next_r.cnt = `SMSF_ZERO_CNT;
					next_r.red_n = `SMSF_ZERO_CODE;
					// flash counts for restorable faults; internal ones show steady red instead
					case (run_err)
						SMSF_ERR_OVERCUR:
						begin
							next_r.red_n = `SMSF_RED_ONE; // R13
							next_r.blue_n = `SMSF_BLUE_OVERCUR;
						end
						SMSF_ERR_SHORT:
						begin
							next_r.red_n = `SMSF_RED_ONE; // R14
							next_r.blue_n = `SMSF_BLUE_SHORT;
						end
						SMSF_ERR_TEMP:
						begin
							next_r.red_n = `SMSF_RED_ONE; // R15
							next_r.blue_n = `SMSF_BLUE_TEMP;
						end
						SMSF_ERR_APP:
						begin
							// no red flash: the code belongs to the application, not the module
							next_r.blue_n = app_error_code; // R16
						end
						default:
						begin
							next_r.blue_n = `SMSF_ZERO_CODE;
						end
					endcase
					next_r.red_left = next_r.red_n;
					next_r.blue_left = next_r.blue_n;
				end
				else
				begin
					// inputs are taken only while healthy, so the fault edge cannot move them
					next_r.inputs = r.sync2; // R2
					next_r.safe = app_safe;
					next_r.sig = app_signal;
				end
			end

			SMSF_ERROR:
			begin
				// latched: no exit, inputs and signalling outputs frozen
				next_r.safe = '0; // R7
				next_r.inputs = r.inputs; // R8
				next_r.sig = r.sig; // R9
				if (r.err == SMSF_ERR_NONE || r.err > SMSF_ERR_APP)
				begin
					// an error without a valid cause can only be an upset; show it as non-restorable
					next_r.err = SMSF_ERR_INTERNAL; // R12
				end
				else if (r.err != SMSF_ERR_INTERNAL) // R10
				begin
					// one counter times every phase, so repeats keep the same rhythm
					if (r.cnt != `SMSF_ZERO_CNT)
					begin
						next_r.cnt = r.cnt - `SMSF_CNT_W'(1);
					end
					else
					begin
						case (r.ph)
							SMSF_PH_ON:
							begin
								next_r.ph = SMSF_PH_GAP;
								next_r.cnt = FLASH_GAP_CYCLES - `SMSF_CNT_W'(1);
								if (r.flash_red)
								begin
									next_r.red_left = r.red_left - `SMSF_CODE_W'(1);
								end
								else
								begin
									next_r.blue_left = r.blue_left - `SMSF_CODE_W'(1);
								end
							end
							SMSF_PH_GAP:
							begin
								// reds go first, then blues
								if (r.red_left != `SMSF_ZERO_CODE || r.blue_left != `SMSF_ZERO_CODE)
								begin
									next_r.ph = SMSF_PH_ON;
									next_r.cnt = FLASH_ON_CYCLES - `SMSF_CNT_W'(1);
									next_r.flash_red = (r.red_left != `SMSF_ZERO_CODE);
								end
								else
								begin
									next_r.ph = SMSF_PH_PAUSE; // R17
									next_r.cnt = PAUSE_CYCLES - `SMSF_CNT_W'(1);
								end
							end
							SMSF_PH_PAUSE:
							begin
								// restart the same code
								next_r.ph = SMSF_PH_GAP; // R17
								next_r.red_left = r.red_n;
								next_r.blue_left = r.blue_n;
							end
							default:
							begin
								next_r.ph = SMSF_PH_GAP;
							end
						endcase
					end
				end
			end

			default:
			begin
				// an unknown state is treated as an internal fault: outputs open, lamps red
				next_r.st = SMSF_ERROR;
				next_r.err = SMSF_ERR_INTERNAL;
				next_r.safe = '0;
			end
		endcase

		// lamps follow the next state so they change on the same edge as it
		next_r.lamp_red = 1'h0;
		next_r.lamp_blue = 1'h0;
		case (next_r.st)
			SMSF_POWER_ON:
			begin
				// self-diagnosis in progress
				next_r.lamp_red = 1'h1; // R1
			end
			SMSF_RUN:
			begin
				// a healthy run keeps both processor lamps dark
				next_r.lamp_red = 1'h0; // R4
				next_r.lamp_blue = 1'h0;
			end
			SMSF_ERROR:
			begin
				if (next_r.err == SMSF_ERR_INTERNAL)
				begin
					// steady red with no flash code marks a fault that needs repair
					next_r.lamp_red = 1'h1; // R3
				end
				else if (next_r.ph == SMSF_PH_ON)
				begin
					next_r.lamp_red = next_r.flash_red; // R13
					next_r.lamp_blue = !next_r.flash_red; // R16
				end
			end
			default:
			begin
				next_r.lamp_red = 1'h1;
				next_r.lamp_blue = 1'h0;
			end
		endcase
	end

	// reset stands for removal and return of supply: the only way out of error
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			r <= '0;
			r.st <= SMSF_POWER_ON;
			r.err <= SMSF_ERR_NONE;
			r.ph <= SMSF_PH_GAP;
			// power-on shows red from the very first moment, before any edge
			r.lamp_red <= 1'h1; // R1
		end
		else
		begin
			r <= next_r;
		end
	end

	// outputs other than app_run, supply_lamp and input_lamps come straight from the state register; app_run is a decode of r.st
	assign app_run = (r.st == SMSF_RUN); // R8
	assign sys_inputs = r.inputs; // R8
	assign safe_switch_outputs = r.safe;
	assign signal_outputs = r.sig; // R9
	assign processor_lamp_a_red = r.lamp_red; // R12
	assign processor_lamp_b_red = r.lamp_red;
	assign processor_lamp_a_blue = r.lamp_blue;
	assign processor_lamp_b_blue = r.lamp_blue;
	// no processor in the path: these lamps work even when the state machine is stuck
	assign supply_lamp = 1'h1; // R11
	assign input_lamps = in_pins; // R11

endmodule

/* test/smsf_field.sv */
// field contacts model: guards, emergency stop and start contacts
`timescale 1ns/1ps
module smsf_field
(
	// clock
	input  wire logic       clk_sys,
	// contact levels wanted by the bench
	input  wire logic [7:0] want,
	// raw contact pins
	output logic      [7:0] in_pins
);
	// contacts move off the clock edge, like real switches
	always @(posedge clk_sys)
		in_pins <= #2 want;
endmodule

/* test/smsf_checker.sv */
// property checker for the state and fault signaller
`timescale 1ns/1ps
module smsf_checker
#(
	parameter logic [31:0] POWER_ON_CYCLES = 32'h8
)
(
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic       self_test_fail,
	input  wire logic       hw_fault,
	input  wire logic       overcurrent_fault,
	input  wire logic       os_short_fault,
	input  wire logic       over_temp_fault,
	input  wire logic       app_error_req,
	input  wire logic       app_run,
	input  wire logic [7:0] sys_inputs,
	input  wire logic [2:0] app_safe,
	input  wire logic [3:0] app_signal,
	input  wire logic [2:0] safe_switch_outputs,
	input  wire logic [3:0] signal_outputs,
	input  wire logic       processor_lamp_a_red,
	input  wire logic       processor_lamp_a_blue,
	input  wire logic       processor_lamp_b_red,
	input  wire logic       processor_lamp_b_blue
);
	logic [31:0] po_cnt;
	// edges since release, saturating so a long run never wraps
	always_ff @(posedge clk_sys or negedge arst_n)
		if (!arst_n)
			po_cnt <= 32'h0;
		else if (po_cnt != 32'hFFFFFFFF)
			po_cnt <= po_cnt + 32'h1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	power_on_red_a: assert property (po_cnt < POWER_ON_CYCLES |-> processor_lamp_a_red && !app_run)
		else $error("lamps not red or run too early in power-on");
	run_entry_a: assert property ($rose(app_run) |-> po_cnt == POWER_ON_CYCLES && !processor_lamp_a_red)
		else $error("run entered at wrong time");
	run_dark_a: assert property (app_run |-> !processor_lamp_a_red && !processor_lamp_a_blue)
		else $error("lamps lit in run");
	test_fail_a: assert property (self_test_fail && po_cnt < POWER_ON_CYCLES |=> processor_lamp_a_red[*8])
		else $error("failed self test not steady red");
	lamps_same_a: assert property (processor_lamp_a_red == processor_lamp_b_red
		&& processor_lamp_a_blue == processor_lamp_b_blue)
		else $error("processor lamps differ");
	fault_open_a: assert property (app_run && (hw_fault || overcurrent_fault || os_short_fault
		|| over_temp_fault || app_error_req) |=> !app_run && safe_switch_outputs == 3'h0)
		else $error("fault did not open outputs");
	safe_idle_a: assert property (!app_run |-> safe_switch_outputs == 3'h0)
		else $error("safety output closed outside run");
	run_copy_a: assert property (app_run && $past(app_run) |-> safe_switch_outputs == $past(app_safe)
		&& signal_outputs == $past(app_signal))
		else $error("outputs do not follow application");
	sig_hold_a: assert property (!app_run |-> $stable(signal_outputs))
		else $error("signal outputs moved outside run");
	in_freeze_a: assert property (!app_run |-> $stable(sys_inputs))
		else $error("inputs evaluated outside run");
endmodule
bind smsf_top smsf_checker #(.POWER_ON_CYCLES(POWER_ON_CYCLES)) i_chk (.clk_sys, .arst_n, .self_test_fail,
	.hw_fault, .overcurrent_fault, .os_short_fault, .over_temp_fault, .app_error_req, .app_run, .sys_inputs,
	.app_safe, .app_signal, .safe_switch_outputs, .signal_outputs, .processor_lamp_a_red,
	.processor_lamp_a_blue, .processor_lamp_b_red, .processor_lamp_b_blue);

/* test/test_smsf_top.sv */
// self-checking bench for the state and fault signaller
`timescale 1ns/1ps
module test_smsf_top;
	logic       clk_sys, arst_n, self_test_fail, hw_fault, overcurrent_fault, os_short_fault, supply_lamp;
	logic       over_temp_fault, app_error_req, app_run, processor_lamp_a_red, processor_lamp_a_blue;
	logic       processor_lamp_b_red, processor_lamp_b_blue;
	logic [7:0] field, in_pins, sys_inputs, input_lamps;
	logic [2:0] app_safe, safe_switch_outputs;
	logic [3:0] app_signal, signal_outputs, app_error_code;
	int         mismatches, check_count;
	smsf_field i_field (.clk_sys, .want(field), .in_pins);
	smsf_top #(.POWER_ON_CYCLES(32'h8), .FLASH_ON_CYCLES(32'h4), .FLASH_GAP_CYCLES(32'h3),
		.PAUSE_CYCLES(32'hA)) i_dut (.clk_sys, .arst_n, .in_pins, .self_test_fail, .hw_fault,
		.overcurrent_fault, .os_short_fault, .over_temp_fault, .app_run, .sys_inputs, .app_safe,
		.app_signal, .app_error_req, .app_error_code, .safe_switch_outputs, .signal_outputs,
		.processor_lamp_a_red, .processor_lamp_a_blue, .processor_lamp_b_red, .processor_lamp_b_blue,
		.supply_lamp, .input_lamps);
	initial
	begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic do_reset;
		arst_n = 1'h0;
		{self_test_fail, hw_fault, overcurrent_fault, os_short_fault, over_temp_fault, app_error_req,
			app_safe, app_signal, app_error_code, field} = 25'h0;
		step(2);
		arst_n = 1'h1;
	endtask
	task automatic t_power;
		do_reset();
		app_safe = 3'h5;
		app_signal = 4'hA;
		field = 8'h3C;
		step(4);
		check({app_run, processor_lamp_a_red, processor_lamp_b_red}, 8'h3);
		check(input_lamps, 8'h3C);
		check(supply_lamp, 8'h1);
		step(4);
		check({app_run, processor_lamp_a_red, processor_lamp_b_red}, 8'h4);
		step(4);
		check({safe_switch_outputs, signal_outputs}, 8'h5A);
		check(sys_inputs, 8'h3C);
		$display("power-on test done");
	endtask
	task automatic t_selftest;
		do_reset();
		app_safe = 3'h7;
		self_test_fail = 1'h1;
		step(1);
		self_test_fail = 1'h0;
		step(20);
		check({app_run, processor_lamp_a_red, safe_switch_outputs}, 8'h8);
		$display("self-test failure test done");
	endtask
	// k picks the fault, w is the sampling window in cycles, er and eb the lit cycles
	task automatic t_fault(input int k, input int w, input int er, input int eb);
		int red_on;
		int blue_on;
		int i;
		red_on = 0;
		blue_on = 0;
		do_reset();
		app_safe = 3'h7;
		app_signal = 4'h6;
		field = 8'h81;
		step(12);
		app_signal = 4'h9;
		app_error_code = 4'h2;
		{hw_fault, overcurrent_fault, os_short_fault, over_temp_fault, app_error_req} = 5'h1 << k;
		step(1);
		{hw_fault, overcurrent_fault, os_short_fault, over_temp_fault, app_error_req} = 5'h0;
		field = 8'h18;
		app_signal = 4'h3;
		check({app_run, safe_switch_outputs, signal_outputs}, 8'h06);
		for (i = 0; i < w; i++)
		begin
			red_on += processor_lamp_a_red;
			blue_on += processor_lamp_a_blue;
			step(1);
		end
		check({8'(red_on)}, 8'(er));
		check({8'(blue_on)}, 8'(eb));
		check({app_run, safe_switch_outputs, signal_outputs}, 8'h06);
		check(sys_inputs, 8'h81);
		check(input_lamps, 8'h18);
		$display("fault test %0d done", k);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#6000;
		mismatches++;
		give_verdict();
	end
	initial
	begin
		mismatches = 0;
		check_count = 0;
		t_power();
		t_selftest();
		t_fault(4, 24, 24, 0);
		t_fault(3, 30, 8, 4);
		t_fault(2, 31, 4, 8);
		t_fault(1, 38, 4, 12);
		t_fault(0, 24, 0, 8);
		give_verdict();
	end
endmodule
